//--- include/smcs_pkg.sv
// constants, field layouts and state types for the serial mode and clock select block
// assumes every file of the block imports this package whole
package smcs_pkg;
  // mode field bit positions
  localparam int MODE_SYNC_BIT = 7;
  localparam int MODE_LEN7_BIT = 6;
  localparam int MODE_PAR_BIT = 5;
  localparam int MODE_ODD_BIT = 4;
  localparam int MODE_STOP_BIT = 3;
  localparam int MODE_MULTI_BIT = 2;
  localparam int MODE_CKS_HI_BIT = 1;
  localparam int MODE_CKS_LO_BIT = 0;
  // control field bit positions
  localparam int CTL_TX_EN_BIT = 5;
  localparam int CTL_RX_EN_BIT = 4;
  localparam int CTL_CKE_HI_BIT = 1;
  localparam int CTL_CKE_LO_BIT = 0;
  // prescaler terminal counts for phi, phi/4, phi/16, phi/64
  localparam logic [5:0] PRE_LIMIT_0 = 6'h00;
  localparam logic [5:0] PRE_LIMIT_1 = 6'h03;
  localparam logic [5:0] PRE_LIMIT_2 = 6'h0f;
  localparam logic [5:0] PRE_LIMIT_3 = 6'h3f;
  // oversampling and framing counts
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_PHASE = 4'h7;
  localparam logic [3:0] CARD_ERR_PHASE = 4'hc;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_7 = 4'h7;
  localparam logic [1:0] GUARD_ETU = 2'h2;
  localparam logic [1:0] STOP_ONE = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h2;
  localparam logic [7:0] FIELD_RESET = 8'h00;

  typedef struct packed {
    logic sync;
    logic chr7;
    logic par_en;
    logic odd;
    logic mp;
    logic two_stop;
    logic card;
  } smcs_fmt_t;

  typedef struct packed {
    logic overrun;
    logic parity;
    logic framing;
    logic brk;
  } smcs_err_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } smcs_tx_state_t;

  typedef enum logic [5:0] {
    RX_IDLE = 6'b000001,
    RX_START = 6'b000010,
    RX_DATA = 6'b000100,
    RX_PAR = 6'b001000,
    RX_STOP = 6'b010000,
    RX_ERRSIG = 6'b100000
  } smcs_rx_state_t;
endpackage

//--- hw/smcs_sync.sv
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to mclk; only q is read outside
`timescale 1ns/1ps
`default_nettype none
module smcs_sync
  import smcs_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= '1;
      q <= '1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

//--- hw/smcs_baud.sv
// prescaler and baud rate counter; tick is one pulse per 16th of an async bit
// assumes divisor and select come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module smcs_baud
  import smcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] prescale_sel,
  input wire logic [7:0] divisor,
  output logic tick
);
  logic [5:0] pre_cnt;
  logic [5:0] pre_limit;
  logic [8:0] brg_cnt;
  logic [1:0] sel_seen;
  logic [7:0] div_seen;
  logic changed;

  always_comb begin
    case (prescale_sel)
      2'b00: pre_limit = PRE_LIMIT_0;
      2'b01: pre_limit = PRE_LIMIT_1;
      2'b10: pre_limit = PRE_LIMIT_2;
      default: pre_limit = PRE_LIMIT_3;
    endcase
  end

  assign changed = (sel_seen != prescale_sel) || (div_seen != divisor);

  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_seen <= 2'b00;
      div_seen <= FIELD_RESET;
    end else begin
      sel_seen <= prescale_sel;
      div_seen <= divisor;
    end
  end

  // 16 ticks of 2*(N+1)*4^n cycles make one bit of (N+1)*64*2^(2n-1) cycles
  always_ff @(posedge mclk) begin
    if (rst || changed) begin
      pre_cnt <= 6'h00;
      brg_cnt <= 9'h000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (pre_cnt == pre_limit) begin
        pre_cnt <= 6'h00;
        if (brg_cnt == {divisor, 1'b1}) begin
          brg_cnt <= 9'h000;
          tick <= 1'b1;
        end else begin
          brg_cnt <= brg_cnt + 9'h001;
        end
      end else begin
        pre_cnt <= pre_cnt + 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/smcs_top.sv
// serial mode, frame format and clock source selection with a minimal transmitter and receiver
// assumes software clears both enables before changing mode, format or clock fields
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - prescaler select gives phi, /4, /16, /64
// - async bit period (N+1)*64*2^(2n-1) cycles
// - bit 7 picks async or clocked sync
// - bit 6 picks 8 or 7 data bits
// - bit 5 adds parity when multiproc off
// - bit 3 picks one or two stops
// - multiproc bit replaces parity when set
// - async receiver flags framing, parity, overrun, break
// - sync receiver flags overrun only
// - async clock enables: none, output, external
// - sync internal clock driven out on pin
// - sync external clock taken from pin
// - card mode: async, 8 data plus parity
// - card transmit keeps two etu guard
// - card parity error drives line low
// - card error signal triggers retransmission
// - divisor 0..255, prescaler select 0..3
// - start low, lsb first, high stops
// - receiver samples on eighth 16x pulse
module smcs_top
  import smcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] serial_mode_field,
  input wire logic [7:0] serial_control_field,
  input wire logic [7:0] baud_divisor,
  input wire logic card_enable,
  input wire logic [7:0] tx_data,
  input wire logic tx_mpb,
  input wire logic tx_load,
  output logic tx_ready,
  output logic tx_busy,
  output logic [7:0] rx_data,
  output logic rx_mpb,
  output logic rx_valid,
  input wire logic rx_ack,
  output smcs_err_t rx_errors,
  input wire logic err_clear,
  output logic txd_o,
  output logic txd_oe,
  input wire logic rxd_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic sck_i
);
  smcs_fmt_t fmt;
  smcs_tx_state_t tx_state;
  smcs_rx_state_t rx_state;
  logic transmit_enable;
  logic receive_enable;
  logic clock_enable_hi;
  logic clock_enable_lo;
  logic tick;
  logic rxd_s;
  logic sck_s;
  logic rxd_prev;
  logic sck_prev;
  logic clk16;
  logic sck_int;
  logic sync_run;
  logic s_fall;
  logic s_rise;
  logic [3:0] nbits;
  logic [1:0] stop_need;
  logic tx_adv;
  logic load_take;
  logic stop_last;
  logic [7:0] hold;
  logic hold_mpb;
  logic hold_full;
  logic [7:0] tx_sh;
  logic [7:0] retry;
  logic retry_mpb;
  logic [3:0] tx_cnt;
  logic [1:0] stop_cnt;
  logic [3:0] tx_ph;
  logic tx_bit;
  logic err_seen;
  logic rx_sample;
  logic [3:0] rx_ph;
  logic [3:0] rx_cnt;
  logic [7:0] rx_sh;
  logic rx_par;
  logic [3:0] err_cnt;
  logic err_drive;
  logic deliver;
  logic [7:0] rx_word;
  logic par_bad;
  logic stop_bad;

  assign transmit_enable = serial_control_field[CTL_TX_EN_BIT];
  assign receive_enable = serial_control_field[CTL_RX_EN_BIT];
  assign clock_enable_hi = serial_control_field[CTL_CKE_HI_BIT];
  assign clock_enable_lo = serial_control_field[CTL_CKE_LO_BIT];

  // card mode overrides the mode field into async 8 data plus parity
  always_comb begin
    fmt.card = card_enable;
    fmt.sync = serial_mode_field[MODE_SYNC_BIT] & ~card_enable;
    fmt.chr7 = ~fmt.sync & ~card_enable & serial_mode_field[MODE_LEN7_BIT];
    fmt.mp = ~fmt.sync & ~card_enable & serial_mode_field[MODE_MULTI_BIT];
    fmt.par_en = ~fmt.sync & (card_enable | (serial_mode_field[MODE_PAR_BIT] & ~fmt.mp));
    fmt.odd = serial_mode_field[MODE_ODD_BIT];
    fmt.two_stop = ~fmt.sync & serial_mode_field[MODE_STOP_BIT];
  end

  assign nbits = fmt.chr7 ? DATA_BITS_7 : DATA_BITS_8;
  assign stop_need = fmt.card ? GUARD_ETU : (fmt.two_stop ? STOP_TWO : STOP_ONE);

  smcs_baud u_baud (
    .mclk(mclk),
    .rst(rst),
    .prescale_sel({serial_mode_field[MODE_CKS_HI_BIT], serial_mode_field[MODE_CKS_LO_BIT]}),
    .divisor(baud_divisor),
    .tick(tick)
  );

  smcs_sync #(.WIDTH(2)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({rxd_i, sck_i}),
    .q({rxd_s, sck_s})
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      rxd_prev <= 1'b1;
      sck_prev <= 1'b1;
    end else begin
      rxd_prev <= rxd_s;
      sck_prev <= sck_s;
    end
  end

  // async 16x enable: generator tick, or pin edge with the generator bypassed
  assign clk16 = ~fmt.sync & (clock_enable_hi ? (sck_s & ~sck_prev) : tick);

  // sync internal clock idles high and only runs while there is work
  assign sync_run = fmt.sync & ~clock_enable_hi & ((tx_state != TX_IDLE) | hold_full | receive_enable);

  always_ff @(posedge mclk) begin
    if (rst) begin
      sck_int <= 1'b1;
    end else if (!sync_run) begin
      sck_int <= 1'b1;
    end else if (tick) begin
      sck_int <= ~sck_int;
    end
  end

  // sync edges: internal from the toggling clock, external from the pin
  always_comb begin
    if (!fmt.sync) begin
      s_fall = 1'b0;
      s_rise = 1'b0;
    end else if (clock_enable_hi) begin
      s_fall = sck_prev & ~sck_s;
      s_rise = ~sck_prev & sck_s;
    end else begin
      s_fall = sync_run & tick & sck_int;
      s_rise = sync_run & tick & ~sck_int;
    end
  end

  // transmit bit phase; also the source of the async output clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_ph <= 4'h0;
    end else if (clk16) begin
      tx_ph <= tx_ph + 4'h1;
    end
  end

  assign tx_adv = fmt.sync ? s_fall : (clk16 && tx_ph == OVERSAMPLE_LAST);
  assign stop_last = tx_state == TX_STOP && stop_cnt == stop_need - 2'h1 && !(fmt.card && err_seen);
  // a full hold starts the next frame right after the last stop, with no extra mark bit
  assign load_take = transmit_enable && tx_adv && hold_full && (tx_state == TX_IDLE || stop_last);

  always_ff @(posedge mclk) begin
    if (rst) begin
      hold <= FIELD_RESET;
      hold_mpb <= 1'b0;
      hold_full <= 1'b0;
    end else if (!transmit_enable) begin
      hold_full <= 1'b0;
    end else if (tx_load && !hold_full) begin
      hold <= tx_data;
      hold_mpb <= tx_mpb;
      hold_full <= 1'b1;
    end else if (load_take) begin
      hold_full <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      tx_bit <= 1'b1;
      tx_sh <= FIELD_RESET;
      retry <= FIELD_RESET;
      retry_mpb <= 1'b0;
      tx_cnt <= 4'h0;
      stop_cnt <= 2'h0;
    end else if (!transmit_enable) begin
      tx_state <= TX_IDLE;
      tx_bit <= 1'b1;
    end else if (tx_adv) begin
      case (tx_state)
        TX_IDLE: begin
          if (hold_full) begin
            retry <= hold;
            retry_mpb <= hold_mpb;
            if (fmt.sync) begin
              tx_bit <= hold[0];
              tx_sh <= {1'b0, hold[7:1]};
              tx_cnt <= 4'h1;
              tx_state <= TX_DATA;
            end else begin
              tx_bit <= 1'b0;
              tx_sh <= hold;
              tx_state <= TX_START;
            end
          end
        end
        TX_START: begin
          tx_bit <= tx_sh[0];
          tx_sh <= {1'b0, tx_sh[7:1]};
          tx_cnt <= 4'h1;
          tx_state <= TX_DATA;
        end
        TX_DATA: begin
          if (tx_cnt == nbits) begin
            if (fmt.sync) begin
              tx_bit <= 1'b1;
              tx_state <= TX_IDLE;
            end else if (fmt.mp) begin
              tx_bit <= retry_mpb;
              tx_state <= TX_PAR;
            end else if (fmt.par_en) begin
              tx_bit <= (^(fmt.chr7 ? {1'b0, retry[6:0]} : retry)) ^ fmt.odd;
              tx_state <= TX_PAR;
            end else begin
              tx_bit <= 1'b1;
              stop_cnt <= 2'h0;
              tx_state <= TX_STOP;
            end
          end else begin
            tx_bit <= tx_sh[0];
            tx_sh <= {1'b0, tx_sh[7:1]};
            tx_cnt <= tx_cnt + 4'h1;
          end
        end
        TX_PAR: begin
          tx_bit <= 1'b1;
          stop_cnt <= 2'h0;
          tx_state <= TX_STOP;
        end
        TX_STOP: begin
          if (stop_cnt == stop_need - 2'h1) begin
            if (fmt.card && err_seen) begin
              tx_bit <= 1'b0;
              tx_sh <= retry;
              tx_state <= TX_START;
            end else if (hold_full) begin
              retry <= hold;
              retry_mpb <= hold_mpb;
              tx_bit <= 1'b0;
              tx_sh <= hold;
              tx_state <= TX_START;
            end else begin
              tx_state <= TX_IDLE;
            end
          end else begin
            stop_cnt <= stop_cnt + 2'h1;
          end
        end
        default: begin
          tx_state <= TX_IDLE;
          tx_bit <= 1'b1;
        end
      endcase
    end
  end

  // error signal from the card falls in the first guard etu; sampled late in it
  always_ff @(posedge mclk) begin
    if (rst) begin
      err_seen <= 1'b0;
    end else if (tx_state == TX_START) begin
      err_seen <= 1'b0;
    end else if (fmt.card && tx_state == TX_STOP && stop_cnt == 2'h0 && clk16 && tx_ph == CARD_ERR_PHASE) begin
      err_seen <= ~rxd_s;
    end
  end

  assign rx_sample = clk16 && rx_ph == SAMPLE_PHASE;
  assign rx_word = fmt.chr7 ? {1'b0, rx_sh[7:1]} : rx_sh;
  assign par_bad = fmt.par_en && (rx_par != ((^rx_word) ^ fmt.odd));
  assign stop_bad = ~rxd_s;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_ph <= 4'h0;
    end else if (rx_state == RX_IDLE) begin
      rx_ph <= 4'h0;
    end else if (clk16) begin
      rx_ph <= rx_ph + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      rx_sh <= FIELD_RESET;
      rx_cnt <= 4'h0;
      rx_par <= 1'b0;
      err_cnt <= 4'h0;
    end else if (!receive_enable) begin
      rx_state <= RX_IDLE;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_cnt <= 4'h0;
          if (fmt.sync) begin
            rx_state <= RX_DATA;
          end else if (rxd_prev && !rxd_s) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_sample) begin
            rx_state <= rxd_s ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (fmt.sync ? s_rise : rx_sample) begin
            rx_sh <= {rxd_s, rx_sh[7:1]};
            if (rx_cnt == nbits - 4'h1) begin
              rx_cnt <= 4'h0;
              if (fmt.sync) begin
                rx_state <= RX_DATA;
              end else if (fmt.par_en || fmt.mp) begin
                rx_state <= RX_PAR;
              end else begin
                rx_state <= RX_STOP;
              end
            end else begin
              rx_cnt <= rx_cnt + 4'h1;
            end
          end
        end
        RX_PAR: begin
          if (rx_sample) begin
            rx_par <= rxd_s;
            rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          // the first stop sample sits at 10.5 etu, where the card error signal begins
          if (rx_sample) begin
            err_cnt <= 4'h0;
            rx_state <= (fmt.card && par_bad) ? RX_ERRSIG : RX_IDLE;
          end
        end
        RX_ERRSIG: begin
          if (clk16) begin
            err_cnt <= err_cnt + 4'h1;
            if (err_cnt == OVERSAMPLE_LAST) begin
              rx_state <= RX_IDLE;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  assign err_drive = rx_state == RX_ERRSIG;
  assign deliver = (rx_state == RX_STOP && rx_sample) ||
                   (fmt.sync && rx_state == RX_DATA && s_rise && rx_cnt == nbits - 4'h1);

  // a pending word is not overwritten; a set wins over a same-cycle clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_data <= FIELD_RESET;
      rx_mpb <= 1'b0;
      rx_valid <= 1'b0;
    end else if (deliver && (!rx_valid || rx_ack)) begin
      rx_data <= fmt.sync ? {rxd_s, rx_sh[7:1]} : rx_word;
      rx_mpb <= fmt.mp & rx_par;
      rx_valid <= 1'b1;
    end else if (rx_ack) begin
      rx_valid <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_errors <= '0;
    end else begin
      if (deliver && rx_valid && !rx_ack) begin
        rx_errors.overrun <= 1'b1;
      end else if (err_clear) begin
        rx_errors.overrun <= 1'b0;
      end
      if (deliver && !fmt.sync && par_bad) begin
        rx_errors.parity <= 1'b1;
      end else if (err_clear) begin
        rx_errors.parity <= 1'b0;
      end
      if (deliver && !fmt.sync && stop_bad) begin
        rx_errors.framing <= 1'b1;
      end else if (err_clear) begin
        rx_errors.framing <= 1'b0;
      end
      // a parity bit left from an earlier frame must not hide a break
      if (deliver && !fmt.sync && stop_bad && rx_word == 8'h00 && !((fmt.par_en || fmt.mp) && rx_par)) begin
        rx_errors.brk <= 1'b1;
      end else if (err_clear) begin
        rx_errors.brk <= 1'b0;
      end
    end
  end

  // card line is open drain: drive only lows, the pull-up makes the highs
  always_ff @(posedge mclk) begin
    if (rst) begin
      txd_o <= 1'b1;
      txd_oe <= 1'b0;
      tx_ready <= 1'b0;
      tx_busy <= 1'b0;
    end else begin
      txd_o <= tx_bit & ~err_drive;
      txd_oe <= fmt.card ? (err_drive | ~tx_bit) : transmit_enable;
      tx_ready <= transmit_enable & ~hold_full & ~(tx_load & ~hold_full);
      tx_busy <= (tx_state != TX_IDLE) | hold_full;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sck_o <= 1'b1;
      sck_oe <= 1'b0;
    end else if (fmt.sync) begin
      sck_o <= sck_int;
      sck_oe <= ~clock_enable_hi;
    end else begin
      sck_o <= tx_ph[3];
      sck_oe <= ~clock_enable_hi & clock_enable_lo;
    end
  end
endmodule
`default_nettype wire

//--- test/smcs_chk.sv
// port checker for smcs_top: clock pin use, load handshake, error flags, bit period
// assumes config fields change only while both enables are low
`timescale 1ns/1ps
`default_nettype none
module smcs_chk
  import smcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] serial_mode_field,
  input wire logic [7:0] serial_control_field,
  input wire logic [7:0] baud_divisor,
  input wire logic card_enable,
  input wire logic tx_load,
  input wire logic tx_ready,
  input wire logic tx_busy,
  input wire smcs_err_t rx_errors,
  input wire logic txd_o,
  input wire logic txd_oe,
  input wire logic sck_o,
  input wire logic sck_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic sy, hi, te, aout, sck_q, seen;
  logic [7:0] div_q;
  logic [1:0] pre_q;
  logic [3:0] ev;
  int cnt, per;
  assign sy = serial_mode_field[MODE_SYNC_BIT] & ~card_enable;
  assign hi = serial_control_field[CTL_CKE_HI_BIT];
  assign te = serial_control_field[CTL_TX_EN_BIT];
  assign aout = ~sy & ~hi & serial_control_field[CTL_CKE_LO_BIT];
  assign ev = rx_errors;
  assign per = (int'(baud_divisor) + 1) * 32 << (2 * int'(serial_mode_field[1:0]));
  // a rate change restarts the counters, so the first rise after it is not timed
  always_ff @(posedge mclk) begin
    sck_q <= sck_o;
    div_q <= baud_divisor;
    pre_q <= serial_mode_field[1:0];
    if (rst || !aout || div_q != baud_divisor || pre_q != serial_mode_field[1:0]) begin
      seen <= 1'b0;
      cnt <= 0;
    end else if (sck_o && !sck_q) begin
      seen <= 1'b1;
      cnt <= 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
  sequence s_take;
    tx_load && tx_ready;
  endsequence
  sequence s_held(x);
    x [*2];
  endsequence
  reset_idle_a: assert property ($fell(rst) |-> txd_o && !txd_oe && !sck_oe && !tx_ready)
    else $error("outputs not idle after reset");
  load_take_a: assert property (s_take |=> !tx_ready ##1 tx_busy)
    else $error("load not taken");
  async_clkout_a: assert property (s_held(aout) |-> sck_oe)
    else $error("async clock not driven");
  ext_clock_a: assert property (s_held(hi) |-> !sck_oe)
    else $error("clock pin driven with external clock");
  sync_clkout_a: assert property (s_held(sy && !hi) |-> sck_oe)
    else $error("sync clock not driven");
  txd_drive_a: assert property (s_held(!card_enable && $stable(te)) |-> txd_oe == te)
    else $error("data line enable wrong");
  sync_errs_a: assert property (sy |-> (ev[2:0] & ~$past(ev[2:0])) == 3'h0)
    else $error("format error flagged in sync mode");
  bit_period_a: assert property (aout && seen && sck_o && !sck_q |-> cnt == per)
    else $error("bit period wrong");
endmodule
bind smcs_top smcs_chk chk (.mclk(mclk), .rst(rst), .serial_mode_field(serial_mode_field),
  .serial_control_field(serial_control_field), .baud_divisor(baud_divisor), .card_enable(card_enable),
  .tx_load(tx_load), .tx_ready(tx_ready), .tx_busy(tx_busy), .rx_errors(rx_errors),
  .txd_o(txd_o), .txd_oe(txd_oe), .sck_o(sck_o), .sck_oe(sck_oe));
`default_nettype wire

//--- test/smcs_remote.sv
// remote serial device on the two data lines
// assumes the bit time of 32 system clocks that the bench sets up
`timescale 1ns/1ps
`default_nettype none
module smcs_remote
  import smcs_pkg::*;
(
  input wire logic mclk,
  input wire logic line_in,
  output logic line_out
);
  int bit_len = 32;
  initial line_out = 1'b1;
  task automatic send(input logic [11:0] bits, input int n);
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (bit_len) @(posedge mclk);
    end
    line_out <= 1'b1;
  endtask
  // sampling at mid bit tolerates a few cycles of edge latency
  task automatic grab(input int n, output logic [12:0] bits, output logic ok);
    int t;
    bits = 13'h0000;
    t = 0;
    while (line_in !== 1'b0 && t < 5000) begin
      @(posedge mclk);
      t++;
    end
    ok = t < 5000;
    repeat (bit_len / 2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      bits[i] = line_in;
      repeat (bit_len) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

//--- test/smcs_tb_top.sv
// bench: clock pin modes, bit rates, transmit formats, receive errors
// assumes the data line is pulled up where nobody drives it
`timescale 1ns/1ps
`default_nettype none
module smcs_tb_top
  import smcs_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] mode_f = 8'h00;
  logic [7:0] ctl_f = 8'h00;
  logic [7:0] div_f = 8'h00;
  logic [7:0] tx_d = 8'h00;
  logic tx_mpb = 1'b0;
  logic tx_load = 1'b0;
  logic rx_ack = 1'b0;
  logic err_clear = 1'b0;
  logic card = 1'b0;
  logic tx_ready, tx_busy, rx_mpb, rx_valid, txd_o, txd_oe, sck_o, sck_oe, rx_line;
  logic [7:0] rx_data;
  smcs_err_t rx_errors;
  wire logic line_tx;
  int bad_count = 0;
  int n_checks = 0;
  assign line_tx = txd_oe ? txd_o : 1'b1;
  always #4 mclk = ~mclk;
  smcs_top uut (.mclk(mclk), .rst(rst), .serial_mode_field(mode_f), .serial_control_field(ctl_f),
    .baud_divisor(div_f), .card_enable(card), .tx_data(tx_d), .tx_mpb(tx_mpb), .tx_load(tx_load),
    .tx_ready(tx_ready), .tx_busy(tx_busy), .rx_data(rx_data), .rx_mpb(rx_mpb), .rx_valid(rx_valid),
    .rx_ack(rx_ack), .rx_errors(rx_errors), .err_clear(err_clear), .txd_o(txd_o), .txd_oe(txd_oe),
    .rxd_i(rx_line), .sck_o(sck_o), .sck_oe(sck_oe), .sck_i(1'b1)); // no clock edges offered
  smcs_remote remote (.mclk(mclk), .line_in(line_tx), .line_out(rx_line));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // enables drop before the fields change, as software must do
  task automatic setup(input logic [7:0] m, input logic [7:0] c, input logic [7:0] d);
    @(posedge mclk);
    ctl_f <= 8'h00;
    @(posedge mclk);
    mode_f <= m;
    div_f <= d;
    @(posedge mclk);
    ctl_f <= c;
    repeat (4) @(posedge mclk);
  endtask
  task automatic load(input logic [7:0] d, input logic mpb);
    int t;
    t = 0;
    while (tx_ready !== 1'b1 && t < 5000) begin
      @(posedge mclk);
      t++;
    end
    tx_d <= d;
    tx_mpb <= mpb;
    tx_load <= 1'b1;
    @(posedge mclk);
    tx_load <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic t_clk(input logic [7:0] m, input logic [7:0] c, input logic e);
    setup(m, c, 8'h00);
    repeat (8) @(posedge mclk);
    check("clock pin enable", {15'h0000, e}, {15'h0000, sck_oe});
    $display("clock pin test done");
  endtask
  task automatic t_rate(input logic [1:0] n);
    int c;
    int r;
    logic p;
    setup({6'h00, n}, 8'h01, 8'h01);
    c = 0;
    r = 0;
    p = sck_o;
    while (r < 2 && c < 9000) begin
      @(posedge mclk);
      c++;
      if (sck_o === 1'b1 && p === 1'b0) begin
        r++;
        c = (r == 1) ? 0 : c;
      end
      p = sck_o;
    end
    check("bit period", 16'(64 << (2 * n)), 16'(c));
    $display("bit rate test done");
  endtask
  // two loads back to back: the bit after the last stop must be the next start
  task automatic t_tx(input logic [7:0] m, input logic [7:0] d, input logic mpb);
    logic [15:0] exp;
    logic [12:0] got;
    logic ok;
    int k;
    exp = 16'h8000;
    k = 1;
    for (int i = 0; i < (m[6] ? 7 : 8); i++) begin
      exp[k] = d[i];
      k++;
    end
    exp[k] = m[2] ? mpb : (^(d & (m[6] ? 8'h7f : 8'hff)) ^ m[4]);
    k = k + (m[2] | m[5]);
    exp[k] = 1'b1;
    exp[k + 1] = m[3];
    setup(m, 8'h20, 8'h00);
    load(d, mpb);
    fork
      remote.grab(k + 2 + m[3], got, ok);
      load(d, mpb);
    join
    check("tx frame", exp, {ok, 2'h0, got});
    $display("transmit test done");
  endtask
  task automatic t_rx(input logic [7:0] m, input logic [11:0] f, input int n, input logic [7:0] ed,
    input logic [3:0] ee, input logic keep);
    setup(m, 8'h10, 8'h00);
    remote.send(f, n);
    repeat (3) @(posedge mclk);
    check("rx word", {2'h0, m[2] & f[m[6] ? 8 : 9], 1'b1, ee, ed}, {2'h0, rx_mpb, rx_valid, rx_errors, rx_data});
    if (!keep) begin
      rx_ack <= 1'b1;
      err_clear <= 1'b1;
      @(posedge mclk);
      rx_ack <= 1'b0;
      err_clear <= 1'b0;
    end
    $display("receive test done");
  endtask
  // card receive with a bad parity bit: the line is pulled low near 11 etu, then let go
  task automatic t_card();
    setup(8'h00, 8'h00, 8'h00);
    card <= 1'b1;
    setup(8'h00, 8'h10, 8'h00);
    remote.send({2'b01, 1'b0, 8'h01, 1'b0}, 11);
    repeat (4) @(posedge mclk);
    check("card error signal", 16'h0004, {11'h000, line_tx, rx_errors});
    repeat (32) @(posedge mclk);
    check("card line release", 16'h0014, {11'h000, line_tx, rx_errors});
    $display("card test done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge mclk);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_clk(8'h00, 8'h10, 1'b0);
    t_clk(8'h00, 8'h11, 1'b1);
    t_clk(8'h00, 8'h12, 1'b0);
    t_clk(8'h80, 8'h11, 1'b1);
    t_clk(8'h80, 8'h13, 1'b0);
    for (int i = 0; i < 4; i++) begin
      t_rate(2'(i));
    end
    t_tx(8'h00, 8'ha5, 1'b0);
    t_tx(8'h08, 8'h3c, 1'b0);
    t_tx(8'h20, 8'h07, 1'b0);
    t_tx(8'h38, 8'h07, 1'b0);
    t_tx(8'h40, 8'hc1, 1'b0);
    t_tx(8'h64, 8'h81, 1'b1);
    t_rx(8'h00, {3'b001, 8'ha5, 1'b0}, 10, 8'ha5, 4'h0, 1'b1);
    t_rx(8'h00, {3'b001, 8'h3c, 1'b0}, 10, 8'ha5, 4'h8, 1'b0);
    t_rx(8'h20, {3'b010, 8'h01, 1'b0}, 11, 8'h01, 4'h4, 1'b0);
    t_rx(8'h04, {2'b01, 1'b1, 8'h5a, 1'b0}, 11, 8'h5a, 4'h0, 1'b0);
    t_rx(8'h00, {3'b000, 8'h55, 1'b0}, 10, 8'h55, 4'h2, 1'b0);
    t_rx(8'h00, {3'b000, 8'h00, 1'b0}, 10, 8'h00, 4'h3, 1'b0);
    t_card();
    stop_test();
  end
endmodule
`default_nettype wire
